// File: design/i2c_slave.sv
/*
 Two-wire slave receive/transmit engine with Avalon-MM register access.
 Assumes: bus lines are open drain and resolved outside; SCL and SDA are
 asynchronous and much slower than the 250 MHz clock; a master engine
 outside this block consumes start_launch and reports arb_lost.
*/
// Notes on behaviour
// [R1] General call byte acked: status 90, next byte acked per ack_enable.
// [R2] General call byte nacked: status 98, then not-addressed mode.
// [R3] Clearing flag with start_request while leaving: queue START for a free bus.
// [R4] STOP or repeated START while addressed: status A0, clear returns to idle.
// [R5] Back in idle, general call answered only when gen_call_enable is set.
// [R6] Software masks prescaler bits before comparing status codes; the bench compares the whole byte, these bits reading as zero.
// [R7] Address register: seven address bits high, general call enable in bit 0.
// [R8] Software arms slave mode: enable and ack set, start, stop, flag clear.
// [R9] Armed device matches address; read bit picks transmit, else receive.
// [R10] After own address and direction: flag set, valid status code shown.
// [R11] Own address with read after lost arbitration reports status B0.
// [R12] ack_enable cleared in transmit: last byte, then C0 on NACK, C8 on ACK.
// [R13] After last byte the device goes idle and leaves SDA released.
// [R14] With ack_enable clear no address is answered, bus still watched.
// [R15] In deep sleep address matching still runs and raises wake.
// [R16] After a wake match SCL is held low until software clears the flag.
// [R17] Data register is not updated while in deep sleep.
// [R18] Misplaced START or STOP: status 00; stop_request plus clear releases lines.
// [R19] Status reads F8 whenever the flag is clear.
// [R20] Flag set in a transfer stretches SCL until software writes one to it.
`timescale 1ns/1ps
module i2c_slave (
	input wire logic clock,
	input wire logic reset,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic arb_lost,
	input wire logic sleep_deep,
	output logic wake_request,
	output logic start_launch,
	output logic irq_request
);

	i2c_slave_pkg::slave_state_s s_reg;
	i2c_slave_pkg::slave_state_s s_next;

	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic bus_wr;
	logic sw_clear;
	logic leaving;

	// Address decode used by the register write logic only; the read mux has its own default
	function automatic logic mapped(input logic [4:0] a);
		return a == i2c_slave_pkg::OFS_CONTROL || a == i2c_slave_pkg::OFS_STATUS ||
			a == i2c_slave_pkg::OFS_DATA || a == i2c_slave_pkg::OFS_ADDRESS;
	endfunction

	// Own address or enabled general call, only while acking is enabled
	function automatic logic addr_match(input logic [7:0] sh, input logic [7:0] own, input logic ack_en);
		logic own_hit;
		logic gc_hit;
		own_hit = sh[7:1] == own[7:1];
		gc_hit = sh == 8'h00 && own[i2c_slave_pkg::ADDR_GCE];
		return ack_en && (own_hit || gc_hit);
	endfunction

	// Status codes after which a cleared flag leaves the addressed state
	function automatic logic ends_transfer(input logic [7:0] c);
		return c == i2c_slave_pkg::ST_RX_NACK || c == i2c_slave_pkg::ST_GC_NACK ||
			c == i2c_slave_pkg::ST_STOP || c == i2c_slave_pkg::ST_TX_NACK ||
			c == i2c_slave_pkg::ST_TX_LAST_ACK || c == i2c_slave_pkg::ST_BUS_ERROR;
	endfunction

	// Edges seen on the second and third stages only
	assign scl_rise = s_reg.scl_s[1] && !s_reg.scl_s[2];
	assign scl_fall = !s_reg.scl_s[1] && s_reg.scl_s[2];
	assign start_ev = s_reg.scl_s[1] && s_reg.scl_s[2] && !s_reg.sda_s[1] && s_reg.sda_s[2];
	assign stop_ev = s_reg.scl_s[1] && s_reg.scl_s[2] && s_reg.sda_s[1] && !s_reg.sda_s[2];

	// A write takes effect on the edge where waitrequest is seen low
	assign bus_wr = avs_write && s_reg.bus_ack && avs_byteenable[0];
	assign sw_clear = bus_wr && avs_address == i2c_slave_pkg::OFS_CONTROL &&
		avs_writedata[i2c_slave_pkg::CTL_FLAG] && s_reg.control[i2c_slave_pkg::CTL_FLAG];
	assign leaving = ends_transfer(s_reg.code);

	always_comb begin
		s_next = s_reg;
		s_next.scl_s = {s_reg.scl_s[1:0], scl_in};
		s_next.sda_s = {s_reg.sda_s[1:0], sda_in};
		s_next.wake = 1'b0;
		s_next.launch = 1'b0;

		// One wait state per access; read data captured while waitrequest is high
		s_next.bus_ack = (avs_read || avs_write) && !s_reg.bus_ack;
		if (avs_read && !s_reg.bus_ack) begin
			s_next.rdata = 32'h0000_0000;
			unique case (avs_address)
				i2c_slave_pkg::OFS_CONTROL: s_next.rdata[7:0] = s_reg.control;
				// [R19] idle code
				i2c_slave_pkg::OFS_STATUS: s_next.rdata[7:0] =
					s_reg.control[i2c_slave_pkg::CTL_FLAG] ? s_reg.code : i2c_slave_pkg::ST_NO_INFO;
				i2c_slave_pkg::OFS_DATA: s_next.rdata[7:0] = s_reg.data;
				i2c_slave_pkg::OFS_ADDRESS: s_next.rdata[7:0] = s_reg.own_addr;
				default: s_next.rdata = 32'h0000_0000;
			endcase
		end

		// Register writes; unmapped offsets are accepted and dropped
		if (bus_wr && mapped(avs_address)) begin
			unique case (avs_address)
				i2c_slave_pkg::OFS_CONTROL: begin
					s_next.control = avs_writedata[7:0];
					s_next.control[i2c_slave_pkg::CTL_WCOL] = s_reg.control[i2c_slave_pkg::CTL_WCOL];
					// Flag is cleared by writing one, a zero leaves it alone
					s_next.control[i2c_slave_pkg::CTL_FLAG] =
						s_reg.control[i2c_slave_pkg::CTL_FLAG] && !avs_writedata[i2c_slave_pkg::CTL_FLAG];
				end
				i2c_slave_pkg::OFS_DATA: begin
					// Loading while the engine owns the byte is a collision
					if (s_reg.control[i2c_slave_pkg::CTL_FLAG]) begin
						s_next.data = avs_writedata[7:0];
						s_next.control[i2c_slave_pkg::CTL_WCOL] = 1'b0;
					end else begin
						s_next.control[i2c_slave_pkg::CTL_WCOL] = 1'b1;
					end
				end
				// [R7] address and general call enable
				i2c_slave_pkg::OFS_ADDRESS: s_next.own_addr = avs_writedata[7:0];
				default: s_next.own_addr = s_reg.own_addr;
			endcase
		end

		// Bus is busy from any START to the next STOP
		if (start_ev) begin
			s_next.bus_busy = 1'b1;
		end else if (stop_ev) begin
			s_next.bus_busy = 1'b0;
		end

		// [R3] queued START goes out on a free bus
		if (s_reg.start_pending && !s_reg.bus_busy && !start_ev) begin
			s_next.start_pending = 1'b0;
			s_next.launch = 1'b1;
			s_next.control[i2c_slave_pkg::CTL_START] = 1'b0;
		end

		// START and STOP seen by the engine; bit phases run below
		if ((start_ev || stop_ev) && s_reg.phase != i2c_slave_pkg::HOLD) begin
			s_next.sda_oe = 1'b0;
			if ((s_reg.phase == i2c_slave_pkg::RX_BITS && s_reg.bits <= 4'h1) ||
				(s_reg.phase == i2c_slave_pkg::TX_BITS && s_reg.bits == 4'h0)) begin
				// [R4] stop or restart between bytes; a receive STOP follows one SCL rise
				s_next.code = i2c_slave_pkg::ST_STOP;
				s_next.control[i2c_slave_pkg::CTL_FLAG] = 1'b1;
				s_next.phase = i2c_slave_pkg::HOLD;
			end else if (s_reg.phase != i2c_slave_pkg::BUS_IDLE &&
				!(s_reg.phase == i2c_slave_pkg::ADDR_BITS && s_reg.bits == 4'h0)) begin
				// [R18] misplaced condition
				s_next.code = i2c_slave_pkg::ST_BUS_ERROR;
				s_next.control[i2c_slave_pkg::CTL_FLAG] = 1'b1;
				s_next.phase = i2c_slave_pkg::HOLD;
			end else begin
				// Idle or just after START: a START restarts the address byte
				s_next.phase = start_ev ? i2c_slave_pkg::ADDR_BITS : i2c_slave_pkg::BUS_IDLE;
				s_next.bits = 4'h0;
			end
		end else begin
			unique case (s_reg.phase)
				i2c_slave_pkg::BUS_IDLE: begin
					s_next.sda_oe = 1'b0;
				end
				i2c_slave_pkg::ADDR_BITS: begin
					if (scl_rise) begin
						s_next.shifter = {s_reg.shifter[6:0], s_reg.sda_s[1]};
						s_next.bits = s_reg.bits + 4'h1;
					end else if (scl_fall && s_reg.bits == i2c_slave_pkg::BYTE_BITS) begin
						// [R14] [R5] no answer without ack_enable
						if (addr_match(s_reg.shifter, s_reg.own_addr, s_reg.control[i2c_slave_pkg::CTL_ACK])) begin
							s_next.sda_oe = 1'b1;
							s_next.phase = i2c_slave_pkg::ADDR_ACK;
							// [R9] direction bit selects mode
							s_next.is_tx = s_reg.shifter[0];
							s_next.gc = s_reg.shifter[7:1] == 7'h00;
							// [R15] match raises wake
							s_next.wake = sleep_deep;
						end else begin
							s_next.phase = i2c_slave_pkg::BUS_IDLE;
						end
					end
				end
				i2c_slave_pkg::ADDR_ACK: begin
					if (scl_fall) begin
						// [R10] [R11] status after own address
						s_next.sda_oe = 1'b0;
						s_next.control[i2c_slave_pkg::CTL_FLAG] = 1'b1;
						s_next.phase = i2c_slave_pkg::HOLD;
						if (s_reg.is_tx) begin
							s_next.code = arb_lost ? i2c_slave_pkg::ST_ARB_SLA_R : i2c_slave_pkg::ST_SLA_R;
						end else if (s_reg.gc) begin
							s_next.code = arb_lost ? i2c_slave_pkg::ST_ARB_GC : i2c_slave_pkg::ST_GC;
						end else begin
							s_next.code = arb_lost ? i2c_slave_pkg::ST_ARB_SLA_W : i2c_slave_pkg::ST_SLA_W;
						end
					end
				end
				i2c_slave_pkg::RX_BITS: begin
					if (scl_rise) begin
						s_next.shifter = {s_reg.shifter[6:0], s_reg.sda_s[1]};
						s_next.bits = s_reg.bits + 4'h1;
					end else if (scl_fall && s_reg.bits == i2c_slave_pkg::BYTE_BITS) begin
						// [R1] ack follows ack_enable taken at release
						s_next.sda_oe = !s_reg.last;
						s_next.phase = i2c_slave_pkg::RX_ACK;
					end
				end
				i2c_slave_pkg::RX_ACK: begin
					if (scl_fall) begin
						s_next.sda_oe = 1'b0;
						// [R17] data kept stale while asleep
						if (!sleep_deep) begin
							s_next.data = s_reg.shifter;
						end
						s_next.control[i2c_slave_pkg::CTL_FLAG] = 1'b1;
						s_next.phase = i2c_slave_pkg::HOLD;
						// [R1] [R2] general call codes
						if (s_reg.gc) begin
							s_next.code = s_reg.last ? i2c_slave_pkg::ST_GC_NACK : i2c_slave_pkg::ST_GC_ACK;
						end else begin
							s_next.code = s_reg.last ? i2c_slave_pkg::ST_RX_NACK : i2c_slave_pkg::ST_RX_ACK;
						end
					end
				end
				i2c_slave_pkg::TX_BITS: begin
					if (scl_fall) begin
						if (s_reg.bits == i2c_slave_pkg::TX_LAST_BIT) begin
							s_next.sda_oe = 1'b0;
							s_next.phase = i2c_slave_pkg::TX_ACK;
						end else begin
							s_next.shifter = {s_reg.shifter[6:0], 1'b0};
							s_next.sda_oe = !s_reg.shifter[6];
							s_next.bits = s_reg.bits + 4'h1;
						end
					end
				end
				i2c_slave_pkg::TX_ACK: begin
					if (scl_rise) begin
						s_next.acked = !s_reg.sda_s[1];
					end else if (scl_fall) begin
						// [R12] last byte ends in C0 or C8
						s_next.control[i2c_slave_pkg::CTL_FLAG] = 1'b1;
						s_next.phase = i2c_slave_pkg::HOLD;
						if (!s_reg.acked) begin
							s_next.code = i2c_slave_pkg::ST_TX_NACK;
						end else begin
							s_next.code = s_reg.last ? i2c_slave_pkg::ST_TX_LAST_ACK : i2c_slave_pkg::ST_TX_ACK;
						end
					end
				end
				i2c_slave_pkg::HOLD: begin
					if (sw_clear) begin
						s_next.bits = 4'h0;
						s_next.last = !s_next.control[i2c_slave_pkg::CTL_ACK];
						if (leaving) begin
							// [R13] [R2] [R4] back to not-addressed mode, SDA released
							s_next.phase = i2c_slave_pkg::BUS_IDLE;
							s_next.sda_oe = 1'b0;
							if (s_reg.code == i2c_slave_pkg::ST_BUS_ERROR) begin
								// [R18] recovery drops stop_request, no STOP driven
								s_next.control[i2c_slave_pkg::CTL_STOP] = 1'b0;
							end else begin
								// [R3] queue START
								s_next.start_pending = s_next.control[i2c_slave_pkg::CTL_START];
							end
						end else if (s_reg.is_tx) begin
							// First bit goes out while SCL is still held, one cycle of setup
							s_next.shifter = s_next.data;
							s_next.sda_oe = !s_next.data[7];
						end else begin
							s_next.phase = i2c_slave_pkg::RX_BITS;
						end
					end else if (!s_reg.control[i2c_slave_pkg::CTL_FLAG]) begin
						// Transmit setup cycle over, let SCL go
						s_next.phase = i2c_slave_pkg::TX_BITS;
					end
				end
			endcase
		end

		// Disabling the interface abandons any transfer and frees the lines
		if (!s_next.control[i2c_slave_pkg::CTL_ENABLE]) begin
			s_next.phase = i2c_slave_pkg::BUS_IDLE;
			s_next.sda_oe = 1'b0;
			s_next.start_pending = 1'b0;
		end
	end

	// Whole state in one register
	always_ff @(posedge clock) begin
		if (reset) begin
			s_reg <= i2c_slave_pkg::STATE_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// Open-drain lines only ever pull low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign sda_oe = s_reg.sda_oe;
	// [R20] [R16] stretch while flag set
	assign scl_oe = s_reg.phase == i2c_slave_pkg::HOLD;
	assign avs_readdata = s_reg.rdata;
	assign avs_waitrequest = (avs_read || avs_write) && !s_reg.bus_ack;
	assign wake_request = s_reg.wake;
	assign start_launch = s_reg.launch;
	assign irq_request = s_reg.control[i2c_slave_pkg::CTL_FLAG] && s_reg.control[i2c_slave_pkg::CTL_IRQ];

endmodule

// File: pkg/i2c_slave_pkg.sv
/*
 Shared constants and types for the byte-oriented two-wire slave.
 Assumes a single 250 MHz clock domain; the bus lines arrive asynchronously.
*/
package i2c_slave_pkg;

	// Register byte offsets on the Avalon-MM slave
	localparam logic [4:0] OFS_CONTROL = 5'h00;
	localparam logic [4:0] OFS_STATUS = 5'h04;
	localparam logic [4:0] OFS_DATA = 5'h08;
	localparam logic [4:0] OFS_ADDRESS = 5'h0C;

	// Field positions in bus_control
	localparam int CTL_FLAG = 7;
	localparam int CTL_ACK = 6;
	localparam int CTL_START = 5;
	localparam int CTL_STOP = 4;
	localparam int CTL_WCOL = 3;
	localparam int CTL_ENABLE = 2;
	localparam int CTL_IRQ = 0;

	// Field position of the general call enable in slave_address_match
	localparam int ADDR_GCE = 0;

	// Values after reset
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] ADDRESS_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'hFF;
	localparam logic [2:0] LINE_RESET = 3'h7;

	// Status codes, prescaler bits always read as zero
	localparam logic [7:0] ST_BUS_ERROR = 8'h00;
	localparam logic [7:0] ST_SLA_W = 8'h60;
	localparam logic [7:0] ST_ARB_SLA_W = 8'h68;
	localparam logic [7:0] ST_GC = 8'h70;
	localparam logic [7:0] ST_ARB_GC = 8'h78;
	localparam logic [7:0] ST_RX_ACK = 8'h80;
	localparam logic [7:0] ST_RX_NACK = 8'h88;
	localparam logic [7:0] ST_GC_ACK = 8'h90;
	localparam logic [7:0] ST_GC_NACK = 8'h98;
	localparam logic [7:0] ST_STOP = 8'hA0;
	localparam logic [7:0] ST_SLA_R = 8'hA8;
	localparam logic [7:0] ST_ARB_SLA_R = 8'hB0;
	localparam logic [7:0] ST_TX_ACK = 8'hB8;
	localparam logic [7:0] ST_TX_NACK = 8'hC0;
	localparam logic [7:0] ST_TX_LAST_ACK = 8'hC8;
	localparam logic [7:0] ST_NO_INFO = 8'hF8;

	// Bits per byte on the wire
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] TX_LAST_BIT = 4'h7;

	typedef enum logic [2:0] {
		BUS_IDLE,
		ADDR_BITS,
		ADDR_ACK,
		RX_BITS,
		RX_ACK,
		TX_BITS,
		TX_ACK,
		HOLD
	} phase_e;

	typedef struct packed {
		phase_e phase;
		logic [7:0] control;
		logic [7:0] own_addr;
		logic [7:0] data;
		logic [7:0] shifter;
		logic [7:0] code;
		logic [3:0] bits;
		logic gc;
		logic is_tx;
		logic last;
		logic acked;
		logic sda_oe;
		logic start_pending;
		logic launch;
		logic wake;
		logic bus_busy;
		logic bus_ack;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [31:0] rdata;
	} slave_state_s;

	localparam slave_state_s STATE_RESET = '{
		phase: BUS_IDLE,
		control: CONTROL_RESET,
		own_addr: ADDRESS_RESET,
		data: DATA_RESET,
		shifter: 8'h00,
		code: ST_NO_INFO,
		bits: 4'h0,
		gc: 1'b0,
		is_tx: 1'b0,
		last: 1'b0,
		acked: 1'b0,
		sda_oe: 1'b0,
		start_pending: 1'b0,
		launch: 1'b0,
		wake: 1'b0,
		bus_busy: 1'b0,
		bus_ack: 1'b0,
		scl_s: LINE_RESET,
		sda_s: LINE_RESET,
		rdata: 32'h0000_0000
	};

endpackage

// File: testbench/i2c_slave_properties.sv
/*
 Port checker for the two-wire slave engine.
 Assumes it is bound into i2c_slave and sees the resolved line levels.
*/
`timescale 1ns/1ps
module i2c_slave_properties (
	input wire logic clock,
	input wire logic reset,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic sleep_deep,
	input wire logic wake_request,
	input wire logic start_launch
);
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (reset);

	// Request held through one wait state, then accepted
	sequence one_wait_s;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	// A strobe lasting exactly one cycle
	sequence pulse_s(s);
		s ##1 !s;
	endsequence

	a_bus_one_wait:
		assert property ($rose(avs_read || avs_write) |-> one_wait_s) else $error("wait state count wrong");
	a_status_aligned:
		assert property (avs_read && !avs_waitrequest && avs_address == i2c_slave_pkg::OFS_STATUS
			|-> avs_readdata[2:0] == 3'h0) else $error("status low bits set");
	a_read_upper:
		assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
	a_wake_pulse:
		assert property (wake_request |-> $past(sleep_deep) ##0 pulse_s(wake_request)) else $error("bad wake strobe");
	a_launch_free:
		assert property (start_launch |-> (scl_in && sda_in) ##0 pulse_s(start_launch)) else $error("bad start launch");
	// Stretch may only end after a software write
	a_stretch_holds:
		assert property (scl_oe && !avs_write && !$past(avs_write) |=> scl_oe) else $error("stretch ended alone");
	a_sda_when_low:
		assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved with clock high");
	a_pins_open:
		assert property (scl_out == 1'h0 && sda_out == 1'h0) else $error("line driven high");
endmodule

bind i2c_slave i2c_slave_properties u_i2c_slave_properties (
	.clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_in), .scl_out(scl_out),
	.scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .sleep_deep(sleep_deep),
	.wake_request(wake_request), .start_launch(start_launch)
);

// File: testbench/i2c_host.sv
/*
 Behavioural two-wire bus master pulling the lines low.
 Assumes pull-ups in the bench and a 250 MHz clock for timing.
*/
`timescale 1ns/1ps
module i2c_host (
	input wire logic clock,
	input wire logic scl,
	input wire logic sda,
	output logic scl_low,
	output logic sda_low
);
	// Quarter of the 160 ns bit time
	localparam int QUARTER = 10;
	initial begin
		scl_low = 1'h0;
		sda_low = 1'h0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// One bit; a stretched clock is waited out, bounded
	task automatic bit_io(input logic b, output logic r);
		sda_low <= !b;
		tick(QUARTER);
		scl_low <= 1'h0;
		tick(1);
		for (int k = 0; k < 5000 && scl !== 1'h1; k++)
			tick(1);
		tick(QUARTER);
		r = sda;
		tick(QUARTER);
		scl_low <= 1'h1;
		tick(QUARTER);
	endtask
	// Byte MSB first plus acknowledge bit
	task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx, output logic ao);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(ai, ao);
	endtask
	task automatic start();
		sda_low <= 1'h0;
		tick(QUARTER);
		scl_low <= 1'h0;
		tick(2 * QUARTER);
		sda_low <= 1'h1;
		tick(2 * QUARTER);
		scl_low <= 1'h1;
		tick(QUARTER);
	endtask
	// Clock is left standing high after a frame
	task automatic stop();
		sda_low <= 1'h1;
		tick(QUARTER);
		scl_low <= 1'h0;
		tick(2 * QUARTER);
		sda_low <= 1'h0;
		tick(2 * QUARTER);
	endtask
endmodule

// File: testbench/i2c_slave_rx_tx_states_tb.sv
/*
 Self-checking bench for the two-wire slave.
 Assumes i2c_host plays the bus master and this module plays software.
*/
`timescale 1ns/1ps
module i2c_slave_rx_tx_states_tb;
	logic clock, reset, avs_read, avs_write, arb_lost, sleep_deep, scl_out, scl_oe, sda_out, sda_oe;
	logic avs_waitrequest, wake_request, start_launch, irq_request, m_scl_low, m_sda_low, ak;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [7:0] q, rx, d;
	logic [7:0] sent[$];
	int fail_count = 0, check_count = 0, cycles = 0, wakes = 0, launches = 0;
	// Open-drain lines with pull-ups
	wire scl_line = !(scl_oe || m_scl_low);
	wire sda_line = !(sda_oe || m_sda_low);

	i2c_slave u_i2c_slave (.clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .arb_lost(arb_lost), .sleep_deep(sleep_deep),
		.wake_request(wake_request), .start_launch(start_launch), .irq_request(irq_request));
	i2c_host u_i2c_host (.clock(clock), .scl(scl_line), .sda(sda_line), .scl_low(m_scl_low), .sda_low(m_sda_low));

	initial begin
		clock = 1'h0;
		forever #2 clock = !clock;
	end

	// Strobe counters and watchdog
	always @(posedge clock) begin
		cycles <= cycles + 1;
		wakes <= wakes + int'(wake_request);
		launches <= launches + int'(start_launch);
		if (cycles == 40000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (fail_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// Avalon access: hold until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v, output logic [7:0] r);
		logic ok;
		avs_address <= a;
		avs_writedata <= {24'h000000, v};
		avs_write <= w;
		avs_read <= !w;
		ok = 1'h0;
		r = 8'h00;
		// Settled values looked at mid-cycle, the request ends at the edge after
		for (int k = 0; k < 64 && !ok; k++) begin
			@(negedge clock);
			ok = avs_waitrequest === 1'h0;
			r = avs_readdata[7:0];
			@(posedge clock);
		end
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge clock);
	endtask
	task automatic ctl(input logic [7:0] v);
		bus(1'h1, i2c_slave_pkg::OFS_CONTROL, v, q);
	endtask
	// Whole byte compared, prescaler bits expected zero
	task automatic st(input logic [7:0] e);
		bus(1'h0, i2c_slave_pkg::OFS_STATUS, 8'h00, q);
		chk("status", e, q);
	endtask

	initial begin
		reset = 1'h1;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		arb_lost = 1'h0;
		sleep_deep = 1'h0;
		void'($urandom(17615));
		repeat (5) @(posedge clock);
		reset <= 1'h0;
		@(posedge clock);
		bus(1'h0, i2c_slave_pkg::OFS_DATA, 8'h00, q);
		chk("data reset", i2c_slave_pkg::DATA_RESET, q);
		st(i2c_slave_pkg::ST_NO_INFO);
		bus(1'h0, 5'h10, 8'h00, q);
		chk("unmapped", 8'h00, q);
		// Address match over general call enable, ack enable and own address
		for (int i = 0; i < 8; i++) begin
			bus(1'h1, i2c_slave_pkg::OFS_ADDRESS, {7'h2A, i[0]}, q);
			ctl({1'h0, i[1], 6'h04});
			u_i2c_host.start();
			u_i2c_host.xfer(i[2] ? 8'h54 : 8'h00, 1'h1, rx, ak);
			chk("addr ack", {7'h00, !(i[1] && (i[2] || i[0]))}, {7'h00, ak});
			if (!ak) begin
				st(i[2] ? i2c_slave_pkg::ST_SLA_W : i2c_slave_pkg::ST_GC);
				ctl(8'hC4);
				u_i2c_host.stop();
				st(i2c_slave_pkg::ST_STOP);
				ctl(8'hC4);
			end else begin
				u_i2c_host.stop();
				st(i2c_slave_pkg::ST_NO_INFO);
			end
		end
		// General call data, acked then refused, then queued START
		u_i2c_host.start();
		u_i2c_host.xfer(8'h00, 1'h1, rx, ak);
		d = 8'($urandom);
		ctl(8'hC4);
		u_i2c_host.xfer(d, 1'h1, rx, ak);
		st(i2c_slave_pkg::ST_GC_ACK);
		bus(1'h0, i2c_slave_pkg::OFS_DATA, 8'h00, q);
		chk("gc data", d, q);
		ctl(8'h84);
		u_i2c_host.xfer(~d, 1'h1, rx, ak);
		chk("gc nack", 8'h01, {7'h00, ak});
		st(i2c_slave_pkg::ST_GC_NACK);
		ctl(8'hE4);
		chk("early start", 8'h00, 8'(launches));
		u_i2c_host.stop();
		for (int k = 0; k < 200 && launches == 0; k++)
			@(posedge clock);
		chk("start launch", 8'h01, 8'(launches));
		// Transmit: last byte acked, then lost arbitration and NACK
		for (int j = 0; j < 2; j++) begin
			arb_lost <= 1'(j);
			u_i2c_host.start();
			u_i2c_host.xfer(8'h55, 1'h1, rx, ak);
			arb_lost <= 1'h0;
			st(j ? i2c_slave_pkg::ST_ARB_SLA_R : i2c_slave_pkg::ST_SLA_R);
			d = 8'($urandom);
			sent.push_back(d);
			bus(1'h1, i2c_slave_pkg::OFS_DATA, d, q);
			ctl(j ? 8'hC4 : 8'h84);
			u_i2c_host.xfer(8'hFF, 1'(j), rx, ak);
			chk("tx byte", sent.pop_front(), rx);
			st(j ? i2c_slave_pkg::ST_TX_NACK : i2c_slave_pkg::ST_TX_LAST_ACK);
			ctl(8'hC4);
			u_i2c_host.xfer(8'hFF, 1'h1, rx, ak);
			chk("after last", 8'hFF, rx);
			u_i2c_host.stop();
		end
		// Deep sleep: match wakes the part and holds the clock
		sleep_deep <= 1'h1;
		u_i2c_host.start();
		u_i2c_host.xfer(8'h54, 1'h1, rx, ak);
		chk("wake", 8'h01, 8'(wakes));
		repeat (40) @(posedge clock);
		chk("held", 8'h00, {7'h00, scl_line});
		sleep_deep <= 1'h0;
		st(i2c_slave_pkg::ST_SLA_W);
		ctl(8'hC4);
		u_i2c_host.xfer(8'($urandom), 1'h1, rx, ak);
		st(i2c_slave_pkg::ST_RX_ACK);
		ctl(8'hC4);
		u_i2c_host.stop();
		ctl(8'hC4);
		// STOP inside an address byte, then recovery
		u_i2c_host.start();
		repeat (3) u_i2c_host.bit_io(1'h1, ak);
		u_i2c_host.stop();
		st(i2c_slave_pkg::ST_BUS_ERROR);
		ctl(8'h05);
		chk("irq", 8'h01, {7'h00, irq_request});
		ctl(8'h94);
		bus(1'h0, i2c_slave_pkg::OFS_CONTROL, 8'h00, q);
		chk("recover", 8'h04, q);
		chk("lines", 8'h03, {6'h00, scl_line, sda_line});
		finish_test();
	end
endmodule
